// ---- rtl/ptml_consts.svh ----
`ifndef PTML_CONSTS_SVH
`define PTML_CONSTS_SVH

`define PTML_START_CODE    8'h66
`define PTML_LIGHT_EXPECT  8'hFF
`define PTML_STOP_SECOND   8'h00
`define PTML_NIBBLE_FOUR   4'h4
`define PTML_NIBBLE_ZERO   4'h0
`define PTML_COUNT_ZERO    4'h0
`define PTML_COUNT_ONE     4'h1
`define PTML_COUNT_NINE    4'h9
`define PTML_LRC_RESET     8'h00
`define PTML_WORD_RESET    16'h0000
`define PTML_SYNC_STAGES   2

`endif

// ---- rtl/ptml_link.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "ptml_consts.svh"

module ptml_link (
  input  wire logic       link_clk,     // Reader side clock
  input  wire logic       reset,        // Core reset, synchronised here
  input  wire logic       tape_strobe,  // Feed hole strobe pin
  input  wire logic [7:0] tape_data_n,  // Data pins, low for a hole
  output logic            strobe_level, // Synchronised strobe level
  output logic            char_toggle,  // Flips once per new character
  output logic [7:0]      char_hold     // Character, stable until next
);

  logic [1:0] rst_sync;
  logic       link_rst;
  logic [8:0] pin_meta;
  logic [8:0] pin_sync;
  logic       strobe_prev;
  logic [1:0] next_rst_sync;
  logic [8:0] next_pin_meta;
  logic [8:0] next_pin_sync;
  logic       next_strobe_prev;
  logic       next_strobe_level;
  logic       next_char_toggle;
  logic [7:0] next_char_hold;

  assign link_rst = rst_sync[1];

  // Reset and pins each pass two flops on the link clock
  always_comb begin
    next_rst_sync     = {rst_sync[0], reset};
    next_pin_meta     = {tape_strobe, ~tape_data_n};
    next_pin_sync     = pin_meta;
    next_strobe_prev  = pin_sync[8];
    next_strobe_level = pin_sync[8];
    next_char_toggle  = char_toggle;
    next_char_hold    = char_hold;
    // Rising strobe latches the character and flags it to the core
    if (pin_sync[8] && !strobe_prev) begin
      next_char_toggle = ~char_toggle;
      next_char_hold   = pin_sync[7:0];
    end
    if (link_rst) begin
      next_pin_meta     = '0;
      next_pin_sync     = '0;
      next_strobe_prev  = 1'b0;
      next_strobe_level = 1'b0;
      next_char_toggle  = 1'b0;
      next_char_hold    = `PTML_LRC_RESET;
    end
  end

  always_ff @(posedge link_clk) begin
    rst_sync     <= next_rst_sync;
    pin_meta     <= next_pin_meta;
    pin_sync     <= next_pin_sync;
    strobe_prev  <= next_strobe_prev;
    strobe_level <= next_strobe_level;
    char_toggle  <= next_char_toggle;
    char_hold    <= next_char_hold;
  end

endmodule : ptml_link
`default_nettype wire

// ---- rtl/ptml_loader.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "ptml_consts.svh"

module ptml_loader #(
  parameter int ADDR_WIDTH = 16
) (
  input  wire logic                  clk,                   // Core clock
  input  wire logic                  reset,                 // Sync, high
  input  wire logic                  link_clk,              // Reader clock
  input  wire logic                  clear_button,          // Clear pin
  input  wire logic                  load_mode_select_n,    // Low: load
  input  wire logic                  tape_strobe,           // Feed strobe
  input  wire logic [7:0]            tape_data_n,           // Data, low=hole
  output logic                       load_active,           // Loading on
  output logic                       reader_enable_n,       // Reader on, low
  output logic                       reader_motor_on,       // Motor drive
  output logic                       loader_error_n,        // Error, low
  output logic                       light_fail_n,          // Light fail, low
  output logic                       light_check_armed,     // Check armed
  output logic                       nibble_shift_enable,   // Flop A and C
  output logic                       char_load_strobe,      // Flop A and B
  output logic                       lower_nibble_strobe_n, // Lower load, low
  output logic                       char_done,             // Char finishing
  output logic                       upper_nibble_is_four,  // Upper is 4
  output logic                       lower_nibble_is_zero,  // Lower is 0
  output logic                       start_code_seen_n,     // Code 66, low
  output logic                       lrc_clear_n,           // Load-go, low
  output logic                       char_count_pulse_n,    // Count, low
  output logic                       count_is_nine,         // LRC character
  output logic                       lrc_nonzero_n,         // LRC nonzero, low
  output logic                       stop_detected,         // Stop seen
  output logic [3:0]                 char_count,            // Char count
  output logic                       mem_timing_start,      // Write start
  output logic                       mem_phase_one,         // Phase one
  output logic                       mem_phase_two,         // Phase two
  output logic                       mem_phase_three,       // Phase three
  output logic                       mem_phase_four,        // Phase four
  output logic                       mem_write_n,           // Write, low
  output logic                       mem_cycle_n,           // Parity en, low
  output logic                       addr_increment_pulse,  // Address step
  output logic [ADDR_WIDTH-1:0]      mem_addr,              // Write address
  output logic [15:0]                processor_input_bus    // Write data
);

  if (ADDR_WIDTH < 1 || ADDR_WIDTH > 32) begin : g_bad_addr
    $error("ptml_loader: ADDR_WIDTH must be 1 to 32");
  end

  // Link capture and crossing
  logic       link_strobe;
  logic       link_toggle;
  logic [7:0] link_char;
  logic [3:0] sync_q;
  logic       clr_s;
  logic       mode_n_s;
  logic       strobe_s;
  logic       toggle_s;

  ptml_link u_link (
    .link_clk     (link_clk),
    .reset        (reset),
    .tape_strobe  (tape_strobe),
    .tape_data_n  (tape_data_n),
    .strobe_level (link_strobe),
    .char_toggle  (link_toggle),
    .char_hold    (link_char)
  );

  // Pins and link levels pass two flops into the core clock
  ptml_sync #(.WIDTH(4)) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({clear_button, load_mode_select_n, link_strobe, link_toggle}),
    .q     (sync_q)
  );

  assign clr_s    = sync_q[3];
  assign mode_n_s = sync_q[2];
  assign strobe_s = sync_q[1];
  assign toggle_s = sync_q[0];

  // Edge detection and character latch
  logic                clr_prev;
  logic                tog_prev;
  ptml_pkg::ptml_char_t char_data;
  logic                next_clr_prev;
  logic                next_tog_prev;
  ptml_pkg::ptml_char_t next_char_data;
  logic                clear_press;
  logic                char_event;

  assign clear_press = clr_s && !clr_prev;
  assign char_event  = toggle_s != tog_prev;

  // Held character is stable long before its toggle arrives
  always_comb begin
    next_clr_prev  = clr_s;
    next_tog_prev  = toggle_s;
    next_char_data = char_event ? link_char : char_data;
    if (reset) begin
      next_clr_prev  = 1'b0;
      next_tog_prev  = 1'b0;
      next_char_data = `PTML_LRC_RESET;
    end
  end

  always_ff @(posedge clk) begin
    clr_prev  <= next_clr_prev;
    tog_prev  <= next_tog_prev;
    char_data <= next_char_data;
  end

  // Character timing flops A to D
  logic ta, tb, tc, td;
  logic ls_prev, cd_prev;
  logic next_ta, next_tb, next_tc, next_td;
  logic next_ls_prev, next_cd_prev;
  logic ls_rise, ls_fall, cd_rise, cd_fall, lower_load;

  assign char_load_strobe      = ta && tb;
  assign nibble_shift_enable   = ta && tc;
  assign lower_load            = ta && !tb && tc;
  assign lower_nibble_strobe_n = !lower_load;
  assign char_done             = ta && !tb && !tc && td;
  assign ls_rise = char_load_strobe && !ls_prev;
  assign ls_fall = !char_load_strobe && ls_prev;
  assign cd_rise = char_done && !cd_prev;
  assign cd_fall = !char_done && cd_prev;

  always_comb begin
    next_ta      = ta;
    next_tb      = tb;
    next_tc      = tc;
    next_td      = td;
    next_ls_prev = char_load_strobe;
    next_cd_prev = char_done;
    if (reset || clear_press) begin
      next_ta = 1'b0;
      next_tb = 1'b0;
      next_tc = 1'b0;
      next_td = 1'b0;
    end else if (!ta) begin
      if (!tb) begin
        next_tb = 1'b1;
      end else if (!tc) begin
        next_tc = 1'b1;
      end else if (!td) begin
        next_td = 1'b1;
      end else if (char_event) begin
        next_ta = 1'b1;
      end
    end else if (tb) begin
      next_tb = 1'b0;
    end else if (tc) begin
      next_tc = 1'b0;
    end else if (td) begin
      next_td = 1'b0;
    end else if (!strobe_s) begin
      next_ta = 1'b0;
      next_tb = 1'b1;
      next_tc = 1'b1;
      next_td = 1'b1;
    end
    if (reset) begin
      next_ls_prev = 1'b0;
      next_cd_prev = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    ta      <= next_ta;
    tb      <= next_tb;
    tc      <= next_tc;
    td      <= next_td;
    ls_prev <= next_ls_prev;
    cd_prev <= next_cd_prev;
  end

  // Character decoding
  logic pair_first;
  assign upper_nibble_is_four = char_data[7:4] == `PTML_NIBBLE_FOUR;
  assign lower_nibble_is_zero = char_data[3:0] == `PTML_NIBBLE_ZERO;
  assign pair_first = upper_nibble_is_four && lower_nibble_is_zero;

  // Load control, light check, LRC and word assembly
  logic                 light_fail, lrc_error, load_go;
  logic                 stop_pending, stop_seen;
  ptml_pkg::ptml_char_t light_capture, lrc;
  ptml_pkg::ptml_count_t count;
  ptml_pkg::ptml_word_t word;
  logic                 next_load_active, next_armed, next_light_fail;
  logic                 next_lrc_error, next_load_go;
  logic                 next_stop_pending, next_stop_seen;
  ptml_pkg::ptml_char_t next_light_capture, next_lrc;
  ptml_pkg::ptml_count_t next_count;
  ptml_pkg::ptml_word_t next_word;
  logic                 count_pulse;

  assign count_is_nine = count == `PTML_COUNT_NINE;
  // Pulses while loading, and after a stop until the LRC character
  assign count_pulse   = ls_rise
                         && (load_go || (stop_seen && !count_is_nine));

  always_comb begin
    next_load_active   = load_active;
    next_armed         = light_check_armed;
    next_light_fail    = light_fail;
    next_lrc_error     = lrc_error;
    next_load_go       = load_go;
    next_stop_pending  = stop_pending;
    next_stop_seen     = stop_seen;
    next_light_capture = light_capture;
    next_lrc           = lrc;
    next_count         = count;
    next_word          = word;
    // Nibble shift register
    if (char_load_strobe) begin
      next_word = {word[11:0], char_data[7:4]};
    end else if (lower_load) begin
      next_word = {word[11:0], char_data[3:0]};
    end
    // Light check, only ahead of the start code
    if (light_check_armed && ls_fall) begin
      next_light_capture = char_data;
    end
    if (!load_go && !stop_seen && cd_fall) begin
      if (light_check_armed) begin
        next_armed = 1'b0;
        if (light_capture != `PTML_LIGHT_EXPECT) begin
          next_light_fail = 1'b1;
        end
      end else if (pair_first) begin
        next_armed = 1'b1;
      end
      if (char_data == `PTML_START_CODE) begin
        next_load_go = 1'b1;
        next_lrc     = `PTML_LRC_RESET;
        next_count   = `PTML_COUNT_ZERO;
        next_armed   = 1'b0;
      end
    end
    // Character count and LRC accumulation
    if (count_pulse) begin
      if (count_is_nine) begin
        next_count = `PTML_COUNT_ONE;
        next_lrc   = char_data;
      end else begin
        next_count = count + `PTML_COUNT_ONE;
        next_lrc   = lrc ^ char_data;
      end
    end
    // Stop pair and LRC evaluation
    if (cd_fall && load_go) begin
      next_stop_pending = pair_first && !count_is_nine;
      if (stop_pending && char_data == `PTML_STOP_SECOND) begin
        next_stop_seen = 1'b1;
        next_load_go   = 1'b0;
      end
    end
    if (cd_fall && count_is_nine && (load_go || stop_seen)
        && lrc != `PTML_LRC_RESET) begin
      next_lrc_error = 1'b1;
      next_load_go   = 1'b0;
    end
    if (light_fail || lrc_error) begin
      next_load_go = 1'b0;
    end
    // Clear press restarts; errors hold until then
    if (reset || clear_press) begin
      next_load_active   = clear_press && !mode_n_s;
      next_armed         = 1'b0;
      next_light_fail = !reset && next_light_fail && !light_fail;
      next_lrc_error = !reset && next_lrc_error && !lrc_error;
      next_load_go       = 1'b0;
      next_stop_pending  = 1'b0;
      next_stop_seen     = 1'b0;
      next_light_capture = `PTML_LRC_RESET;
      next_lrc           = `PTML_LRC_RESET;
      next_count         = `PTML_COUNT_ZERO;
      next_word          = `PTML_WORD_RESET;
    end
  end

  always_ff @(posedge clk) begin
    load_active       <= next_load_active;
    light_check_armed <= next_armed;
    light_fail        <= next_light_fail;
    lrc_error         <= next_lrc_error;
    load_go           <= next_load_go;
    stop_pending      <= next_stop_pending;
    stop_seen         <= next_stop_seen;
    light_capture     <= next_light_capture;
    lrc               <= next_lrc;
    count             <= next_count;
    word              <= next_word;
  end

  // Status and reader control
  assign reader_enable_n = !(load_active && !light_fail && !lrc_error);
  assign reader_motor_on = !reader_enable_n;
  assign light_fail_n    = !light_fail;
  assign loader_error_n  = !(light_fail || lrc_error);
  assign start_code_seen_n  = char_data != `PTML_START_CODE;
  assign lrc_clear_n        = !load_go;
  assign char_count_pulse_n = !count_pulse;
  assign lrc_nonzero_n      = lrc == `PTML_LRC_RESET;
  assign stop_detected      = stop_seen;
  assign char_count         = count;
  assign mem_timing_start   = cd_rise && load_go && !count[0]
                              && count != `PTML_COUNT_ZERO;

  // Memory timing sequence
  ptml_pkg::ptml_mem_state_t mstate, next_mstate;
  logic [ADDR_WIDTH-1:0]     next_mem_addr;
  ptml_pkg::ptml_word_t      next_bus;
  logic next_p1, next_p2, next_p3, next_p4;
  logic next_write_n, next_cycle_n, next_inc;

  always_comb begin
    next_mstate   = mstate;
    next_mem_addr = mem_addr;
    next_bus      = processor_input_bus;
    unique case (mstate)
      ptml_pkg::MS_IDLE: begin
        if (mem_timing_start) begin
          next_mstate = ptml_pkg::MS_ONE;
          next_bus    = word;
        end
      end
      ptml_pkg::MS_ONE:   next_mstate = ptml_pkg::MS_TWO;
      ptml_pkg::MS_TWO:   next_mstate = ptml_pkg::MS_THREE;
      ptml_pkg::MS_THREE: begin
        next_mstate   = ptml_pkg::MS_INC;
        next_mem_addr = mem_addr + 1'b1;
      end
      ptml_pkg::MS_INC:   next_mstate = ptml_pkg::MS_IDLE;
    endcase
    if (reset || (clear_press && !mode_n_s)) begin
      next_mstate   = ptml_pkg::MS_IDLE;
      next_mem_addr = '0;
      next_bus      = `PTML_WORD_RESET;
    end
    // Registered phase outputs follow the next state
    next_p1      = next_mstate == ptml_pkg::MS_ONE;
    next_p2      = next_mstate == ptml_pkg::MS_TWO
                   || next_mstate == ptml_pkg::MS_THREE
                   || next_mstate == ptml_pkg::MS_INC;
    next_p3      = next_mstate == ptml_pkg::MS_THREE;
    next_p4      = next_mstate != ptml_pkg::MS_IDLE;
    next_write_n = !next_p1;
    next_cycle_n = !(next_mstate == ptml_pkg::MS_TWO);
    next_inc     = next_mstate == ptml_pkg::MS_INC;
  end

  always_ff @(posedge clk) begin
    mstate               <= next_mstate;
    mem_addr             <= next_mem_addr;
    processor_input_bus  <= next_bus;
    mem_phase_one        <= next_p1;
    mem_phase_two        <= next_p2;
    mem_phase_three      <= next_p3;
    mem_phase_four       <= next_p4;
    mem_write_n          <= next_write_n;
    mem_cycle_n          <= next_cycle_n;
    addr_increment_pulse <= next_inc;
  end

endmodule : ptml_loader
`default_nettype wire

// ---- rtl/ptml_pkg.sv ----
package ptml_pkg;

  // Tape character, assembled memory word and character count
  typedef logic [7:0]  ptml_char_t;
  typedef logic [15:0] ptml_word_t;
  typedef logic [3:0]  ptml_count_t;

  // Memory timing sequence
  typedef enum logic [2:0] {
    MS_IDLE,
    MS_ONE,
    MS_TWO,
    MS_THREE,
    MS_INC
  } ptml_mem_state_t;

endpackage : ptml_pkg

// ---- rtl/ptml_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "ptml_consts.svh"

module ptml_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,   // Destination clock
  input  wire logic             reset, // Synchronous reset, active high
  input  wire logic [WIDTH-1:0] d,     // Asynchronous levels
  output logic      [WIDTH-1:0] q      // Synchronised levels
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  if (WIDTH < 1) begin : g_bad_width
    $error("ptml_sync: WIDTH must be at least 1");
  end

  // First stage feeds only the second stage
  always_comb begin
    next_meta = d;
    next_q    = meta;
    if (reset) begin
      next_meta = '0;
      next_q    = '0;
    end
  end

  always_ff @(posedge clk) begin
    meta <= next_meta;
    q    <= next_q;
  end

endmodule : ptml_sync
`default_nettype wire

// ---- test/ptml_loader_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module ptml_loader_tb;
  logic clk = 1'b0, link_clk = 1'b0, reset = 1'b1, clear_button = 1'b0;
  logic load_mode_select_n = 1'b0, tape_strobe, load_active, reader_enable_n;
  logic loader_error_n, light_fail_n, stop_detected, mem_write_n;
  logic reader_motor_on, light_check_armed, upper_nibble_is_four;
  logic lower_nibble_is_zero, start_code_seen_n, lrc_clear_n, lrc_nonzero_n;
  logic [7:0] tape_data_n;
  logic [15:0] mem_addr, processor_input_bus, addr;
  logic [31:0] seed = 32'hfb008bda;
  logic [31:0] q[$];
  int n_errors = 0, samples_checked = 0;
  always #20 clk = ~clk;
  initial begin
    #7;
    forever #16 link_clk = ~link_clk;
  end
  ptml_reader rdr_u (.link_clk(link_clk), .tape_strobe(tape_strobe),
    .tape_data_n(tape_data_n));
  ptml_loader dut_u (.clk, .reset, .link_clk, .clear_button,
    .load_mode_select_n, .tape_strobe, .tape_data_n, .load_active,
    .reader_enable_n, .reader_motor_on, .loader_error_n, .light_fail_n,
    .light_check_armed, .nibble_shift_enable(), .char_load_strobe(),
    .lower_nibble_strobe_n(), .char_done(), .upper_nibble_is_four,
    .lower_nibble_is_zero, .start_code_seen_n, .lrc_clear_n,
    .char_count_pulse_n(), .count_is_nine(), .lrc_nonzero_n,
    .stop_detected, .char_count(), .mem_timing_start(), .mem_phase_one(),
    .mem_phase_two(), .mem_phase_three(), .mem_phase_four(), .mem_write_n,
    .mem_cycle_n(), .addr_increment_pulse(), .mem_addr, .processor_input_bus);
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nxt
  task automatic check(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic press();
    clear_button <= 1'b1;
    repeat (4) @(posedge clk);
    clear_button <= 1'b0;
    repeat (12) @(posedge clk);
    addr = 16'h0000;
  endtask : press
  // Eight data characters then the LRC, noting each expected word
  task automatic blk(input logic [7:0] bad, input bit stp);
    logic [7:0] c, p, lrc;
    lrc = 8'h00;
    p = 8'h00;
    for (int i = 1; i <= 8; i++) begin
      seed = nxt(seed);
      c = (stp && i == 2) ? 8'h40 : (stp && i == 3) ? 8'h00 : seed[7:0] | 8'h80;
      if (i % 2 == 0 && !(stp && i > 2)) begin
        q.push_back({addr, p, c});
        addr++;
      end
      rdr_u.put(c);
      lrc ^= c;
      p = c;
    end
    rdr_u.put(lrc ^ bad);
    repeat (20) @(posedge clk);
  endtask : blk
  // Compares each memory write against the oldest note
  always @(negedge clk) begin
    if (!reset && mem_write_n === 1'b0) begin
      if (q.size() == 0) check("extra write", 32'h1, 32'h0);
      else check("write", {mem_addr, processor_input_bus}, q.pop_front());
    end
  end
  initial begin
    #200000;
    n_errors++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    press();
    check("load_active", load_active, 1'b1);
    check("reader_enable_n", reader_enable_n, 1'b0);
    rdr_u.put(8'h40);
    rdr_u.put(8'hFF);
    rdr_u.put(8'h66);
    check("start_code_seen_n", start_code_seen_n, 1'b0);
    check("lrc_clear_n", lrc_clear_n, 1'b0);
    blk(8'h00, 1'b0);
    blk(8'h00, 1'b1);
    check("stop_detected", stop_detected, 1'b1);
    check("loader_error_n", loader_error_n, 1'b1);
    check("lrc_clear_n", lrc_clear_n, 1'b1);
    check("lrc_nonzero_n", lrc_nonzero_n, 1'b1);
    press();
    rdr_u.put(8'h40);
    check("light_check_armed", light_check_armed, 1'b1);
    check("upper_nibble_is_four", upper_nibble_is_four, 1'b1);
    check("lower_nibble_is_zero", lower_nibble_is_zero, 1'b1);
    rdr_u.put(8'h7E);
    repeat (20) @(posedge clk);
    check("light_fail_n", light_fail_n, 1'b0);
    check("reader_enable_n", reader_enable_n, 1'b1);
    check("reader_motor_on", reader_motor_on, 1'b0);
    // Clear in normal mode ends the session
    load_mode_select_n <= 1'b1;
    press();
    check("load_active", load_active, 1'b0);
    check("reader_motor_on", reader_motor_on, 1'b0);
    load_mode_select_n <= 1'b0;
    repeat (4) @(posedge clk);
    press();
    check("loader_error_n", loader_error_n, 1'b1);
    rdr_u.put(8'h66);
    blk(8'h01, 1'b0);
    check("loader_error_n", loader_error_n, 1'b0);
    check("lrc_nonzero_n", lrc_nonzero_n, 1'b0);
    check("words left", q.size(), 32'h0);
    final_report();
  end
endmodule : ptml_loader_tb
bind ptml_loader ptml_props #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (.clk, .reset,
  .clear_button, .char_load_strobe, .nibble_shift_enable,
  .lower_nibble_strobe_n, .char_done, .mem_timing_start, .mem_phase_one,
  .mem_phase_two, .mem_phase_three, .mem_phase_four, .mem_write_n,
  .mem_cycle_n, .addr_increment_pulse, .mem_addr, .char_count,
  .char_count_pulse_n, .count_is_nine, .stop_detected, .loader_error_n,
  .reader_enable_n, .load_active);
`default_nettype wire

// ---- test/ptml_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module ptml_props #(
  parameter int ADDR_WIDTH = 16
) (
  input wire logic                  clk,                   // Core clock
  input wire logic                  reset,                 // Sync reset
  input wire logic                  clear_button,          // Clear pin
  input wire logic                  char_load_strobe,      // Flop A and B
  input wire logic                  nibble_shift_enable,   // Flop A and C
  input wire logic                  lower_nibble_strobe_n, // Lower load
  input wire logic                  char_done,             // Char ending
  input wire logic                  mem_timing_start,      // Write start
  input wire logic                  mem_phase_one,         // Phase one
  input wire logic                  mem_phase_two,         // Phase two
  input wire logic                  mem_phase_three,       // Phase three
  input wire logic                  mem_phase_four,        // Phase four
  input wire logic                  mem_write_n,           // Write strobe
  input wire logic                  mem_cycle_n,           // Parity enable
  input wire logic                  addr_increment_pulse,  // Address step
  input wire logic [ADDR_WIDTH-1:0] mem_addr,              // Write address
  input wire logic [3:0]            char_count,            // Char count
  input wire logic                  char_count_pulse_n,    // Count pulse
  input wire logic                  count_is_nine,         // LRC character
  input wire logic                  stop_detected,         // Stop seen
  input wire logic                  loader_error_n,        // Error, low
  input wire logic                  reader_enable_n,       // Reader on
  input wire logic                  load_active            // Loading on
);
  logic [2:0] quiet;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Counts cycles since the clear pin was last high, holding at 7
  always_ff @(posedge clk) begin
    quiet <= (reset || clear_button) ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
  end
  a_char_walk: assert property ($rose(char_load_strobe) |=>
    !lower_nibble_strobe_n ##1 char_done ##1 !char_done)
    else $error("character timing out of step");
  a_shift_load: assert property (char_load_strobe |-> nibble_shift_enable)
    else $error("load strobe without shift enable");
  a_write_walk: assert property (mem_timing_start |=>
    (mem_phase_one && !mem_write_n) ##1 (mem_phase_two && !mem_cycle_n)
    ##1 mem_phase_three ##1 addr_increment_pulse ##1 !mem_phase_four)
    else $error("memory timing out of step");
  a_addr_step: assert property (addr_increment_pulse |->
    mem_addr == $past(mem_addr) + 1'b1) else $error("address not stepped");
  a_write_even: assert property (mem_timing_start |-> char_done &&
    !char_count[0] && char_count != 4'h0) else $error("write on odd count");
  a_cycle_phase: assert property (!mem_cycle_n |-> mem_phase_two)
    else $error("memory cycle outside phase two");
  a_error_stops: assert property (!loader_error_n |-> reader_enable_n)
    else $error("reader left on after error");
  a_error_holds: assert property (!loader_error_n && quiet == 3'h7
    |=> !loader_error_n) else $error("error dropped without clear");
  a_count_step: assert property (!char_count_pulse_n |=>
    char_count == ($past(char_count) == 4'h9 ? 4'h1
    : $past(char_count) + 4'h1)) else $error("character count not stepped");
  a_nine_flag: assert property (count_is_nine |-> char_count == 4'h9)
    else $error("count nine flag wrong");
  a_stop_quiet: assert property (stop_detected |-> !mem_timing_start)
    else $error("write after stop code");
  a_load_on: assert property ($rose(load_active) |-> !reader_enable_n)
    else $error("reader off at load start");
  c_write: cover property (mem_timing_start);
  c_error: cover property ($fell(loader_error_n));
  c_stop: cover property ($rose(stop_detected));
endmodule : ptml_props
`default_nettype wire

// ---- test/ptml_reader.sv ----
`timescale 1ns/10ps
`default_nettype none
module ptml_reader (
  input  wire logic  link_clk,    // Reader side clock
  output logic       tape_strobe, // Feed hole strobe
  output logic [7:0] tape_data_n  // Data pins, low for a hole
);
  initial tape_strobe = 1'b0;
  initial tape_data_n = 8'hA5;
  // One tape character; lines show the inverse four link clocks after the strobe drops
  task automatic put(input logic [7:0] c);
    @(posedge link_clk) tape_data_n <= ~c;
    tape_strobe <= 1'b1;
    repeat (10) @(posedge link_clk);
    tape_strobe <= 1'b0;
    repeat (4) @(posedge link_clk);
    tape_data_n <= c;
    repeat (8) @(posedge link_clk);
  endtask : put
endmodule : ptml_reader
`default_nettype wire
